// [hw/can_mbx_regs.svh]
// Register offsets, reset values and bit positions of the mailbox transmit flag block
`ifndef CAN_MBX_REGS_SVH
`define CAN_MBX_REGS_SVH

// ==========================================================
// Register offsets (16-bit registers, byte addresses)
`define OFS_TX_PENDING 4'h0
`define OFS_CANCEL_REQ 4'h2
`define OFS_TX_DONE 4'h4
`define OFS_ABORT_DONE 4'h6
`define OFS_IRQ_STATUS 4'h8
`define OFS_IRQ_MASK 4'hA

// ==========================================================
// Reset values
`define FLAG_RESET 16'h0000
`define IRQ_RESET 2'h0
`define RDATA_RESET 16'h0000

// ==========================================================
// Field positions
`define RSVD_BIT 8
`define IRQ_TX_BIT 0
`define IRQ_AB_BIT 1

`endif

// [hw/can_mbx_pkg.sv]
// Types and bit-order helpers of the mailbox transmit flag block
package can_mbx_pkg;

    // ==========================================================
    // Types
    typedef logic [15:0] mbx_vec_t;
    typedef logic [15:0] reg_word_t;
    typedef logic [3:0] reg_addr_t;
    typedef logic [1:0] irq_vec_t;

    // ==========================================================
    // Mailbox order to register order: mailboxes 7..1 on bits 15..9, 15..8 on 7..0
    function automatic reg_word_t to_reg(input mbx_vec_t m);
        return {m[7:1], 1'b0, m[15:8]};
    endfunction : to_reg

    // Register order to mailbox order; mailbox 0 never appears
    function automatic mbx_vec_t to_mbx(input reg_word_t r);
        return {r[7:0], r[15:9], 1'b0};
    endfunction : to_mbx

endpackage : can_mbx_pkg

// [hw/flag_bank_if.sv]
// Carrier between the top module and one sticky flag bank
`timescale 1ns/100ps
interface flag_bank_if;
    import can_mbx_pkg::*;
    mbx_vec_t set_evt;
    mbx_vec_t clr_req;
    mbx_vec_t flags;
    modport bank (input set_evt, input clr_req, output flags);
    modport user (output set_evt, output clr_req, input flags);
endinterface : flag_bank_if

// [hw/flag_bank.sv]
// Sixteen sticky flags in mailbox order; set wins over clear, mailbox 0 held at zero
`timescale 1ns/100ps
`include "can_mbx_regs.svh"
module flag_bank (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // Flag traffic
    flag_bank_if.bank fb
);
    import can_mbx_pkg::*;

    mbx_vec_t flags_q;
    mbx_vec_t flags_d;

    always_comb begin
        flags_d = flags_q;
        if (ce) begin
            flags_d = (flags_q & ~fb.clr_req) | fb.set_evt;
        end
        flags_d[0] = 1'b0;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flags_q <= `FLAG_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign fb.flags = flags_q;

endmodule : flag_bank

// [hw/can_mailbox_tx_ack_flags.sv]
// Transmit pending, cancel request and done flags of CAN mailboxes 1 to 15
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "can_mbx_regs.svh"
module can_mailbox_tx_ack_flags (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // Register port
    input wire can_mbx_pkg::reg_addr_t addr,
    input wire can_mbx_pkg::reg_word_t wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output can_mbx_pkg::reg_word_t rdata,
    // Protocol engine, mailbox order, one-cycle pulses in
    input wire can_mbx_pkg::mbx_vec_t tx_complete,
    input wire can_mbx_pkg::mbx_vec_t cancel_complete,
    output can_mbx_pkg::mbx_vec_t transmit_pending_bits,
    output can_mbx_pkg::mbx_vec_t cancel_request_bits,
    // Interrupt
    output logic irq
);
    import can_mbx_pkg::*;

    // ==========================================================
    // Register map, byte offsets of 16-bit words
    //   0x0 pending bits, a one sets, cleared by the engine
    //   0x2 cancel requests, a one sets, cleared on completion
    //   0x4 transmit-done flags, write one to clear
    //   0x6 abort-done flags, write one to clear
    //   0x8 interrupt status, bit 0 any send, bit 1 any abort
    //   0xA interrupt mask, same layout as status
    // Pending, cancel and done words share one mailbox bit order

    // ==========================================================
    // Write decode
    logic wr_pend;
    logic wr_canc;
    logic wr_txd;
    logic wr_abd;
    logic wr_ist;
    logic wr_imk;
    mbx_vec_t wr_mbx;
    mbx_vec_t txd_clr;
    mbx_vec_t abd_clr;
    irq_vec_t ist_clr;

    always_comb begin
        // Strobes seen while the clock enable is low are dropped, not queued
        wr_pend = ce && wr_stb && (addr == `OFS_TX_PENDING);
        wr_canc = ce && wr_stb && (addr == `OFS_CANCEL_REQ);
        wr_txd = ce && wr_stb && (addr == `OFS_TX_DONE);
        wr_abd = ce && wr_stb && (addr == `OFS_ABORT_DONE);
        wr_ist = ce && wr_stb && (addr == `OFS_IRQ_STATUS);
        wr_imk = ce && wr_stb && (addr == `OFS_IRQ_MASK);
        // Bit 8 has no mailbox, so it drops out of the remap
        wr_mbx = to_mbx(wdata);
        // Clear masks stay zero unless their own register is written
        txd_clr = wr_txd ? wr_mbx : `FLAG_RESET;
        abd_clr = wr_abd ? wr_mbx : `FLAG_RESET;
        ist_clr = wr_ist ? wdata[1:0] : `IRQ_RESET;
    end

    // ==========================================================
    // Pending and cancel request bits
    // Both are set by software and cleared only by the engine's outcome
    mbx_vec_t pend_q;
    mbx_vec_t pend_d;
    mbx_vec_t canc_q;
    mbx_vec_t canc_d;
    mbx_vec_t tx_evt;
    mbx_vec_t ab_evt;

    always_comb begin
        // Only a mailbox that is waiting can report an outcome
        // A send and an abort of one mailbox in one cycle set both flags
        tx_evt = tx_complete & pend_q;
        ab_evt = cancel_complete & pend_q & canc_q;
        pend_d = pend_q;
        canc_d = canc_q;
        if (ce) begin
            pend_d = pend_q;
            // Writing zero cannot withdraw a request; only a cancel does
            if (wr_pend) begin
                pend_d = pend_d | wr_mbx;
            end
            pend_d = pend_d & ~(tx_evt | ab_evt);
            canc_d = canc_q;
            if (wr_canc) begin
                canc_d = canc_d | wr_mbx;
            end
            // A request left over once the message went out would abort the next one
            canc_d = canc_d & ~(ab_evt | tx_evt);
        end
        pend_d[0] = 1'b0;
        canc_d[0] = 1'b0;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pend_q <= `FLAG_RESET;
            canc_q <= `FLAG_RESET;
        end else begin
            pend_q <= pend_d;
            canc_q <= canc_d;
        end
    end

    assign transmit_pending_bits = pend_q;
    assign cancel_request_bits = canc_q;

    // ==========================================================
    // Done flag banks
    flag_bank_if txd_if ();
    flag_bank_if abd_if ();

    // Both banks force mailbox 0 to zero; bit 8 never reads back as one because to_reg fills it with a constant zero
    // An event and a clear of one flag in one cycle leave the flag set
    always_comb begin
        txd_if.set_evt = tx_evt;
        txd_if.clr_req = txd_clr;
        abd_if.set_evt = ab_evt;
        abd_if.clr_req = abd_clr;
    end

    flag_bank u_tx_done (
        .core_clk(core_clk),
        .resetn(resetn),
        .ce(ce),
        .fb(txd_if.bank)
    );

    flag_bank u_abort_done (
        .core_clk(core_clk),
        .resetn(resetn),
        .ce(ce),
        .fb(abd_if.bank)
    );

    // ==========================================================
    // Interrupt status and mask
    irq_vec_t ist_q;
    irq_vec_t ist_d;
    irq_vec_t imk_q;
    irq_vec_t imk_d;
    irq_vec_t ev_now;

    always_comb begin
        ev_now = `IRQ_RESET;
        ev_now[`IRQ_TX_BIT] = |tx_evt;
        ev_now[`IRQ_AB_BIT] = |ab_evt;
        ist_d = ist_q;
        imk_d = imk_q;
        if (ce) begin
            // New events win over a clear in the same cycle
            ist_d = ist_q & ~ist_clr;
            ist_d = ist_d | ev_now;
            if (wr_imk) begin
                imk_d = wdata[1:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ist_q <= `IRQ_RESET;
            imk_q <= `IRQ_RESET;
        end else begin
            ist_q <= ist_d;
            imk_q <= imk_d;
        end
    end

    // Level output: stays high until software clears the status or masks it
    assign irq = |(ist_q & imk_q);

    // ==========================================================
    // Read port, data valid the cycle after the strobe only
    reg_word_t rdata_q;
    reg_word_t rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (ce) begin
            // Idle cycles return zero so a stale word is never taken for data
            rdata_d = `RDATA_RESET;
            if (rd_stb) begin
                case (addr)
                    `OFS_TX_PENDING: rdata_d = to_reg(pend_q);
                    `OFS_CANCEL_REQ: rdata_d = to_reg(canc_q);
                    `OFS_TX_DONE: rdata_d = to_reg(txd_if.flags);
                    `OFS_ABORT_DONE: rdata_d = to_reg(abd_if.flags);
                    `OFS_IRQ_STATUS: rdata_d = {14'h0000, ist_q};
                    `OFS_IRQ_MASK: rdata_d = {14'h0000, imk_q};
                    default: rdata_d = `RDATA_RESET;
                endcase
                rdata_d[`RSVD_BIT] = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= `RDATA_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

endmodule : can_mailbox_tx_ack_flags

// [tb/tx_flags_monitor.sv]
// Port-level checks of the mailbox transmit flag block
`timescale 1ns/100ps
`include "can_mbx_regs.svh"
module tx_flags_monitor (
    // Clock, reset and enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // Register port
    input wire can_mbx_pkg::reg_addr_t addr,
    input wire can_mbx_pkg::reg_word_t wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire can_mbx_pkg::reg_word_t rdata,
    // Engine side
    input wire can_mbx_pkg::mbx_vec_t tx_complete,
    input wire can_mbx_pkg::mbx_vec_t cancel_complete,
    input wire can_mbx_pkg::mbx_vec_t transmit_pending_bits,
    input wire can_mbx_pkg::mbx_vec_t cancel_request_bits
);
    import can_mbx_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ==========
    // Engine silent, so only software may touch the bits
    sequence s_quiet;
        tx_complete == 16'h0000 && cancel_complete == 16'h0000;
    endsequence
    property p_pset;
        (ce && wr_stb && addr == `OFS_TX_PENDING) ##0 s_quiet |=>
            (transmit_pending_bits[7:1] & $past(wdata[15:9])) == $past(wdata[15:9]) &&
            (transmit_pending_bits[15:8] & $past(wdata[7:0])) == $past(wdata[7:0]);
    endproperty
    a_pset: assert property (p_pset) else $error("pending write not taken");
    property p_cset;
        (ce && wr_stb && addr == `OFS_CANCEL_REQ) ##0 s_quiet |=>
            (cancel_request_bits[7:1] & $past(wdata[15:9])) == $past(wdata[15:9]) &&
            (cancel_request_bits[15:8] & $past(wdata[7:0])) == $past(wdata[7:0]);
    endproperty
    a_cset: assert property (p_cset) else $error("cancel write not taken");
    property p_pclr;
        ce && |(tx_complete & transmit_pending_bits) |=>
            (transmit_pending_bits & $past(tx_complete) & $past(transmit_pending_bits))
                == 16'h0000;
    endproperty
    a_pclr: assert property (p_pclr) else $error("pending kept after send");
    property p_cclr;
        ce && |(cancel_complete & cancel_request_bits & transmit_pending_bits) |=>
            ((cancel_request_bits | transmit_pending_bits) & $past(cancel_complete)
                & $past(cancel_request_bits) & $past(transmit_pending_bits)) == 16'h0000;
    endproperty
    a_cclr: assert property (p_cclr) else $error("cancel or pending kept");
    property p_phold;
        s_quiet |=> (transmit_pending_bits & $past(transmit_pending_bits))
            == $past(transmit_pending_bits);
    endproperty
    a_phold: assert property (p_phold) else $error("pending dropped");
    property p_chold;
        s_quiet |=> (cancel_request_bits & $past(cancel_request_bits))
            == $past(cancel_request_bits);
    endproperty
    a_chold: assert property (p_chold) else $error("cancel dropped");
    property p_mbx0;
        transmit_pending_bits[0] == 1'b0 && cancel_request_bits[0] == 1'b0;
    endproperty
    a_mbx0: assert property (p_mbx0) else $error("mailbox 0 bit set");
    property p_rsvd;
        rdata[`RSVD_BIT] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit read one");
    // Read data stand only in the cycle after the read strobe
    property p_rzero;
        ce && !rd_stb |=> rdata == 16'h0000;
    endproperty
    a_rzero: assert property (p_rzero) else $error("read data outside its cycle");
    property p_freeze;
        !ce |=> $stable(transmit_pending_bits) && $stable(cancel_request_bits)
            && $stable(rdata);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with enable low");
endmodule : tx_flags_monitor

// [tb/can_engine_model.sv]
// Protocol engine stand-in: sends or aborts pending mailboxes
`timescale 1ns/100ps
module can_engine_model #(parameter int LAT = 4) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Mailbox state and events
    input wire can_mbx_pkg::mbx_vec_t pend,
    input wire can_mbx_pkg::mbx_vec_t canc,
    output can_mbx_pkg::mbx_vec_t tx_done,
    output can_mbx_pkg::mbx_vec_t ab_done
);
    import can_mbx_pkg::*;
    int cnt_q;
    int cnt_d;
    always_comb begin
        cnt_d = (|pend && cnt_q < LAT) ? cnt_q + 1 : 0;
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            cnt_q <= 0;
        else
            cnt_q <= cnt_d;
    end
    // Arbitration wait of LAT cycles; a cancel seen by then wins
    assign tx_done = (cnt_q == LAT) ? (pend & ~canc) : 16'h0000;
    assign ab_done = (cnt_q == LAT) ? (pend & canc) : 16'h0000;
endmodule : can_engine_model

// [tb/tb_top.sv]
// Self-checking bench of the mailbox transmit flag block
`timescale 1ns/100ps
`include "can_mbx_regs.svh"
module tb_top;
    import can_mbx_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    reg_addr_t addr = 4'h0;
    reg_word_t wdata = 16'h0000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic ce = 1'b1;
    reg_word_t rdata;
    mbx_vec_t txc, abc, pend, canc;
    logic irq;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    can_mailbox_tx_ack_flags u_can_mailbox_tx_ack_flags (.core_clk(core_clk),
        .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .tx_complete(txc), .cancel_complete(abc),
        .transmit_pending_bits(pend), .cancel_request_bits(canc), .irq(irq));
    can_engine_model u_can_engine_model (.core_clk(core_clk), .resetn(resetn),
        .pend(pend), .canc(canc), .tx_done(txc), .ab_done(abc));
    // ==========
    // Bus tasks
    task automatic chk(input reg_word_t got, input reg_word_t exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input reg_addr_t a, input reg_word_t d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input reg_addr_t a, input reg_word_t exp);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd
    // ==========
    // Scenarios
    task automatic t_reset;
        rd(`OFS_TX_DONE, 16'h0000);
        rd(`OFS_ABORT_DONE, 16'h0000);
        rd(`OFS_TX_PENDING, 16'h0000);
        rd(`OFS_CANCEL_REQ, 16'h0000);
        rd(`OFS_IRQ_STATUS, 16'h0000);
        rd(`OFS_IRQ_MASK, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        rd(4'hE, 16'h0000);
        $display("reset values done");
    endtask : t_reset
    task automatic t_tx;
        wr(`OFS_TX_PENDING, 16'h8381);
        rd(`OFS_TX_PENDING, 16'h8281);
        repeat (8) @(posedge core_clk);
        rd(`OFS_TX_DONE, 16'h8281);
        rd(`OFS_TX_PENDING, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        wr(`OFS_IRQ_MASK, 16'h0003);
        chk({15'h0000, irq}, 16'h0001);
        wr(`OFS_TX_DONE, 16'h0000);
        rd(`OFS_TX_DONE, 16'h8281);
        wr(`OFS_TX_DONE, 16'h0201);
        rd(`OFS_TX_DONE, 16'h8080);
        wr(`OFS_IRQ_STATUS, 16'h0003);
        chk({15'h0000, irq}, 16'h0000);
        $display("transmit done");
    endtask : t_tx
    task automatic t_abort;
        wr(`OFS_TX_PENDING, 16'h0201);
        wr(`OFS_CANCEL_REQ, 16'h0201);
        rd(`OFS_CANCEL_REQ, 16'h0201);
        repeat (8) @(posedge core_clk);
        rd(`OFS_ABORT_DONE, 16'h0201);
        rd(`OFS_CANCEL_REQ, 16'h0000);
        rd(`OFS_TX_PENDING, 16'h0000);
        rd(`OFS_TX_DONE, 16'h8080);
        rd(`OFS_IRQ_STATUS, 16'h0002);
        chk({15'h0000, irq}, 16'h0001);
        wr(`OFS_ABORT_DONE, 16'hFFFF);
        rd(`OFS_ABORT_DONE, 16'h0000);
        $display("abort done");
    endtask : t_abort
    task automatic t_freeze;
        @(posedge core_clk);
        ce <= 1'b0;
        wr(`OFS_TX_PENDING, 16'h0201);
        wr(`OFS_IRQ_MASK, 16'h0000);
        @(posedge core_clk);
        ce <= 1'b1;
        rd(`OFS_TX_PENDING, 16'h0000);
        rd(`OFS_IRQ_MASK, 16'h0003);
        chk({15'h0000, irq}, 16'h0001);
        $display("clock enable freeze done");
    endtask : t_freeze
    task automatic test_done;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_tx();
        t_abort();
        t_freeze();
        test_done();
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            test_done();
        end
    end
endmodule : tb_top
bind can_mailbox_tx_ack_flags tx_flags_monitor u_tx_flags_monitor (.core_clk(core_clk),
    .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata),
    .tx_complete(tx_complete), .cancel_complete(cancel_complete),
    .transmit_pending_bits(transmit_pending_bits), .cancel_request_bits(cancel_request_bits));
